// file: hdl/dmr_top.v
// Behaviour
// - write cas delay is mode2 bits 5:3 plus a base count
// - total write delay is write cas delay plus posted additive delay
// - mode2 bit 6 enables auto rate; disabled means 1x self refresh unless bit 7 is set
// - auto rate doubles self refresh when case temperature is hot
// - mode2 bit 7 forces 2x self refresh always
// - mode2 bits 10:9 nonzero enable write termination
// - write termination replaces nominal during write burst only
// - nominal and write termination independent; nominal off is high-z
// - no write termination switching during write leveling
// - mode3 bit 2 selects calibration reads; bits 1:0 00 is pattern
// - every read and autoprecharge read goes to calibration register
// - calibration data on prime lane per byte or on all lanes
// - calibration reads do burst eight or chop four, a12 on the fly
// - burst eight order 0..7; chop four a2 picks 0..3 or 4..7
// - burst position 0 is lsb, position 7 is msb
// - predefined pattern alternates zero and one
// - bank address 010 loads mode2, 011 loads mode3
`timescale 1ns/1ns
`default_nettype none
`include "dmr_map.vh"
module dmr_top #(
   parameter DQ_W = 8,
   parameter [2:0] CWL_BASE = 3'h5
) (
   input wire clk,
   input wire reset,
   input wire avs_read,
   input wire avs_write,
   input wire [3:0] avs_address,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire ck_pin,
   input wire cs_n_pin,
   input wire ras_n_pin,
   input wire cas_n_pin,
   input wire we_n_pin,
   input wire [2:0] ba_pin,
   input wire [13:0] addr_pin,
   input wire temp_hot_pin,
   output reg [DQ_W-1:0] dq_o,
   output reg dq_oe_n,
   output reg term_wr_q,
   output wire [1:0] term_wr_code,
   output reg sr_rate_2x_q,
   output reg array_rd_q,
   output reg array_wr_q,
   output wire [5:0] total_write_delay
);
   localparam PIN_W = 22;
   // pattern bits, burst position 0 in the lsb
   localparam [7:0] PATTERN = `DMR_PATTERN;
   // synchroniser stages of the command pins and the link clock
   reg [PIN_W-1:0] pin_s1_q;
   reg [PIN_W-1:0] pin_s2_q;
   reg ck_s1_q;
   reg ck_s2_q;
   reg ck_d3_q;
   // mode and control state
   reg [10:0] mr2_q;
   reg [2:0] mr3_q;
   reg [3:0] ctrl_q;
   reg [15:0] dlys_q;
   reg ack_q;
   // write termination and calibration burst counters
   reg [5:0] wr_wait_q;
   reg [2:0] wr_len_q;
   reg [4:0] rd_wait_q;
   reg [3:0] rd_len_q;
   reg [2:0] rd_pos_q;
   // link clock edges seen in the system clock domain
   wire ck_rise;
   wire ck_fall;
   wire ck_edge;
   // synchronised pins
   wire cs_n;
   wire ras_n;
   wire cas_n;
   wire we_n;
   wire temp_hot;
   wire [2:0] ba;
   wire [13:0] addr;
   // decoded commands and derived settings
   wire cmd_mode;
   wire cmd_rd;
   wire cmd_wr;
   wire calib_on;
   wire chop;
   wire wt_en;
   wire rd_emit;
   wire [2:0] write_cas_delay;
   wire [4:0] posted_additive_delay;
   wire [4:0] read_delay;
   wire [3:0] be_bits;
   wire [DQ_W-1:0] lane_mask;
   wire beat_bit;

   // two-flop synchronisers for the link clock and the command pins
   // the pins share the clock's delay, so a command is read in the
   // same cycle as the rising edge that strobes it
   // pins reset to all ones so no command is decoded out of reset
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_d3_q <= 1'b0;
         pin_s1_q <= {PIN_W{1'b1}};
         pin_s2_q <= {PIN_W{1'b1}};
      end else begin
         ck_s1_q <= ck_pin;
         ck_s2_q <= ck_s1_q;
         ck_d3_q <= ck_s2_q;
         pin_s1_q <= {temp_hot_pin, addr_pin, ba_pin, cs_n_pin,
                      ras_n_pin, cas_n_pin, we_n_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   // link clock edges and decoded commands
   // an edge is the second stage differing from the third
   // commands are only decoded on a rising link clock edge
   assign ck_rise = ck_s2_q & ~ck_d3_q;
   assign ck_fall = ~ck_s2_q & ck_d3_q;
   assign ck_edge = ck_rise | ck_fall;
   assign {temp_hot, addr, ba, cs_n, ras_n, cas_n, we_n} = pin_s2_q;
   assign cmd_mode = ck_rise & ~cs_n & ~ras_n & ~cas_n & ~we_n;
   assign cmd_rd = ck_rise & ~cs_n & ras_n & ~cas_n & we_n;
   assign cmd_wr = ck_rise & ~cs_n & ras_n & ~cas_n & ~we_n;

   // mode fields and derived settings
   // the write cas delay field counts upwards from CWL_BASE
   // write leveling blocks the termination switch
   assign write_cas_delay = mr2_q[`DMR_M2_CWL_LO+2:`DMR_M2_CWL_LO];
   assign posted_additive_delay = dlys_q[`DMR_DLYS_AL_LO+4:`DMR_DLYS_AL_LO];
   assign read_delay = dlys_q[`DMR_DLYS_RL_LO+4:`DMR_DLYS_RL_LO];
   assign total_write_delay = {3'h0, write_cas_delay} + {3'h0, CWL_BASE}
      + {1'h0, posted_additive_delay};
   assign term_wr_code = mr2_q[`DMR_M2_WT_LO+1:`DMR_M2_WT_LO];
   assign wt_en = (term_wr_code != 2'h0)
      & ~ctrl_q[`DMR_CTRL_WLEV];
   assign calib_on = mr3_q[`DMR_M3_EN]
      & (mr3_q[1:0] == `DMR_M3_PRE);
   // a12 low asks for chop four when on-the-fly is enabled
   assign chop = ctrl_q[`DMR_CTRL_OTF] ? ~addr[12]
      : ctrl_q[`DMR_CTRL_CHOP];

   // mode-load capture; only the defined bits are kept
   // reserved bits are dropped, so readback shows them as zero
   // other bank codes address mode registers outside this block
   // a new setting is in force one clock after the load
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         mr2_q <= `DMR_M2_RST;
         mr3_q <= `DMR_M3_RST;
      end else if (cmd_mode) begin
         if (ba == `DMR_BA_MR2)
            mr2_q <= addr[10:0] & 11'h6F8;
         else if (ba == `DMR_BA_MR3)
            mr3_q <= addr[2:0];
      end
   end

   // self refresh rate: forced wins, auto follows temperature
   // the temperature pin is a level, already synchronised
   // the level is registered so the output never glitches
   always @(posedge clk or posedge reset) begin
      if (reset)
         sr_rate_2x_q <= 1'b0;
      else
         sr_rate_2x_q <= mr2_q[`DMR_M2_SRT]
            | (mr2_q[`DMR_M2_ASR] & temp_hot);
   end

   // normal array access pulses; reads bypass the array in calib mode
   // writes are kept off the array in calib mode too; the controller
   // keeps them out of calibration mode
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         array_rd_q <= 1'b0;
         array_wr_q <= 1'b0;
      end else begin
         array_rd_q <= cmd_rd & ~mr3_q[`DMR_M3_EN];
         array_wr_q <= cmd_wr & ~mr3_q[`DMR_M3_EN];
      end
   end

   // write termination window, counted in link clock cycles
   // the window opens total_write_delay rises after the write
   // and lasts one link cycle per two beats of the burst
   // a new write restarts the count and closes any open window
   // write leveling only stops the window from opening
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_wait_q <= 6'h00;
         wr_len_q <= 3'h0;
         term_wr_q <= 1'b0;
      end else if (ck_rise) begin
         if (cmd_wr) begin
            wr_wait_q <= total_write_delay;
            wr_len_q <= chop ? `DMR_WRCYC_C4 : `DMR_WRCYC_B8;
            term_wr_q <= 1'b0;
         end else if (wr_wait_q != 6'h00) begin
            wr_wait_q <= wr_wait_q - 6'h01;
            if (wr_wait_q == 6'h01)
               term_wr_q <= wt_en;
         end else if (wr_len_q != 3'h0) begin
            wr_len_q <= wr_len_q - 3'h1;
            if (wr_len_q == 3'h1)
               term_wr_q <= 1'b0;
         end
      end
   end

   // calibration burst: one beat per link clock edge
   // the first beat leaves on the rising edge that ends the delay
   // then each following edge carries the next burst position
   // the lane mask picks the prime lane of each byte or all lanes
   // a read with a reserved pattern select is dropped
   assign rd_emit = ck_edge & (rd_len_q != 4'h0)
      & ((rd_wait_q == 5'h00) | (ck_rise & (rd_wait_q == 5'h01)));
   assign beat_bit = PATTERN[rd_pos_q];
   assign lane_mask = ctrl_q[`DMR_CTRL_ALL] ? {DQ_W{1'b1}}
      : {(DQ_W/8){8'h01}};

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_wait_q <= 5'h00;
         rd_len_q <= 4'h0;
         rd_pos_q <= 3'h0;
         dq_o <= {DQ_W{1'b0}};
         dq_oe_n <= 1'b1;
      end else begin
         if (cmd_rd & calib_on) begin
            rd_wait_q <= read_delay;
            rd_len_q <= chop ? `DMR_BEATS_C4 : `DMR_BEATS_B8;
            // a1:0 ignored; a2 picks the nibble only for chop four
            rd_pos_q <= {chop & addr[2], 2'h0};
         end else begin
            if (ck_rise && rd_wait_q != 5'h00)
               rd_wait_q <= rd_wait_q - 5'h01;
            if (rd_emit) begin
               dq_o <= beat_bit ? lane_mask : {DQ_W{1'b0}};
               dq_oe_n <= 1'b0;
               rd_len_q <= rd_len_q - 4'h1;
               rd_pos_q <= rd_pos_q + 3'h1;
            end else if (ck_edge && rd_wait_q <= 5'h01) begin
               dq_oe_n <= 1'b1;
               dq_o <= {DQ_W{1'b0}};
            end
         end
      end
   end

   // avalon slave: one wait cycle, then the answer
   // the first cycle of a request raises waitrequest and loads
   // read data; the second drops it and commits a write, so both
   // are done by the edge where the master sees waitrequest low
   // unmapped offsets read zero and ignore writes
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign be_bits = avs_byteenable;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ack_q <= 1'b0;
         avs_readdata <= 32'h00000000;
         ctrl_q <= `DMR_CTRL_RST;
         dlys_q <= `DMR_DLYS_RST;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (avs_write && ack_q) begin
            if (avs_address == `DMR_OFS_CTRL && be_bits[0])
               ctrl_q <= avs_writedata[3:0];
            if (avs_address == `DMR_OFS_DLYS) begin
               if (be_bits[0])
                  dlys_q[7:0] <= avs_writedata[7:0] & 8'h1F;
               if (be_bits[1])
                  dlys_q[15:8] <= avs_writedata[15:8] & 8'h1F;
            end
         end
         if (avs_read && !ack_q) begin
            case (avs_address)
               `DMR_OFS_MODE:
                  avs_readdata <= {13'h0000, mr3_q, 5'h00, mr2_q};
               `DMR_OFS_WDLY:
                  avs_readdata <= {26'h0000000, total_write_delay};
               `DMR_OFS_CTRL:
                  avs_readdata <= {28'h0000000, ctrl_q};
               `DMR_OFS_DLYS:
                  avs_readdata <= {16'h0000, dlys_q};
               default:
                  avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/dmr_map.vh
`ifndef DMR_MAP_VH
`define DMR_MAP_VH
// register byte offsets on the avalon slave
`define DMR_OFS_MODE 4'h0
`define DMR_OFS_WDLY 4'h4
`define DMR_OFS_CTRL 4'h8
`define DMR_OFS_DLYS 4'hC
// control register bits
`define DMR_CTRL_WLEV 0
`define DMR_CTRL_ALL 1
`define DMR_CTRL_OTF 2
`define DMR_CTRL_CHOP 3
`define DMR_CTRL_RST 4'h4
// delays register fields
`define DMR_DLYS_AL_LO 0
`define DMR_DLYS_RL_LO 8
`define DMR_DLYS_RST 16'h0B00
// mode readback positions
`define DMR_MODE_M3_LO 16
// bank address codes of the mode-load targets
`define DMR_BA_MR2 3'h2
`define DMR_BA_MR3 3'h3
// second mode register fields
`define DMR_M2_CWL_LO 3
`define DMR_M2_ASR 6
`define DMR_M2_SRT 7
`define DMR_M2_WT_LO 9
`define DMR_M2_RST 11'h000
// third mode register fields
`define DMR_M3_EN 2
`define DMR_M3_RST 3'h0
`define DMR_M3_PRE 2'h0
// calibration pattern, burst position 0 in the lsb
`define DMR_PATTERN 8'hAA
// burst lengths in beats, write burst in link cycles
`define DMR_BEATS_B8 4'h8
`define DMR_BEATS_C4 4'h4
`define DMR_WRCYC_B8 3'h4
`define DMR_WRCYC_C4 3'h2
`endif

// file: verification/dmr_props.sv
`timescale 1ns/1ns
`default_nettype none
// port checks of the mode block
module dmr_props #(
   parameter DQ_W = 8,
   parameter [2:0] CWL_BASE = 3'h5
) (
   input wire clk,
   input wire reset,
   input wire [DQ_W-1:0] dq_o,
   input wire dq_oe_n,
   input wire term_wr_q,
   input wire [1:0] term_wr_code,
   input wire array_rd_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // burst and termination windows: open, hold, close
   sequence burst_on; $fell(dq_oe_n); endsequence
   sequence burst_off; !dq_oe_n[*8] ##[6:26] dq_oe_n; endsequence
   sequence term_on; $rose(term_wr_q); endsequence
   burst_len_a: assert property (burst_on |-> burst_off)
      else $error("burst length");
   first_zero_a: assert property (burst_on |-> !dq_o[0])
      else $error("first beat");
   lane_use_a: assert property (!dq_oe_n |->
      dq_o[DQ_W-1:1] == '0 || &dq_o) else $error("lane use");
   beat_alt_a: assert property (!dq_oe_n && !$past(dq_oe_n, 4) |->
      dq_o[0] != $past(dq_o[0], 4)) else $error("pattern");
   term_code_a: assert property (term_wr_q |-> term_wr_code != 2'h0)
      else $error("term code");
   term_read_a: assert property (term_wr_q |-> dq_oe_n)
      else $error("term in read");
   term_len_a: assert property (term_on |->
      term_wr_q[*8] ##[6:26] !term_wr_q) else $error("term length");
   rd_pulse_a: assert property (array_rd_q |=> !array_rd_q)
      else $error("read pulse");
endmodule
bind dmr_top dmr_props #(.DQ_W(DQ_W), .CWL_BASE(CWL_BASE)) chk_u (.clk,
   .reset, .dq_o, .dq_oe_n, .term_wr_q, .term_wr_code, .array_rd_q);
`default_nettype wire

// file: verification/dmr_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// controller side: free running link clock and command pins
module dmr_ctl_model (
   output var logic ck_pin,
   output var logic cs_n_pin,
   output var logic ras_n_pin,
   output var logic cas_n_pin,
   output var logic we_n_pin,
   output var logic [2:0] ba_pin,
   output var logic [13:0] addr_pin
);
   // link clock, phase unrelated to the system clock
   initial begin
      ck_pin = 1'b0;
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 4'hF;
      {ba_pin, addr_pin} = 17'h0;
      #7;
      forever #160 ck_pin = ~ck_pin;
   end
   // one command around a link rise; released lines toggle
   task issue(input [2:0] rcw, input [2:0] ba, input [13:0] a);
      @(negedge ck_pin);
      {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = {1'b0, rcw};
      {ba_pin, addr_pin} = {ba, a};
      @(negedge ck_pin);
      cs_n_pin = 1'b1;
      {ba_pin, addr_pin} = ~{ba, a};
      repeat (8) @(negedge ck_pin);
   endtask
   // mode load, banks idle
   task mode_load_cmd(input [2:0] ba, input [13:0] a);
      if (ba == 3'h3) a = a & 14'h0007;
      if (a[7]) a[6] = 1'b0;
      issue(3'h0, ba, a);
   endtask
   // a12 high for burst eight, a2 only with chop
   task rd(input bc, input hi);
      issue(3'h5, 3'h0, {1'b0, !bc, 9'h0, hi & bc, 2'h0});
   endtask
   task wr(input bc);
      issue(3'h4, 3'h0, {1'b0, !bc, 12'h0});
   endtask
endmodule
`default_nettype wire

// file: verification/dmr_top_test.sv
`timescale 1ns/1ns
`default_nettype none
// self-checking bench of the mode block
module dmr_top_test;
   logic clk, reset, avs_read, avs_write, temp_hot_pin, dq_oe_n, term_wr_q;
   logic avs_waitrequest, ck_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
   logic sr_rate_2x_q, array_rd_q, array_wr_q, hot;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [13:0] addr_pin, m2;
   logic [7:0] dq_o, bq[$];
   logic [5:0] total_write_delay;
   logic [4:0] al;
   logic [2:0] ba_pin;
   logic [1:0] term_wr_code;
   int error_cnt, check_count, tc, ap, i;
   dmr_top #(.DQ_W(8), .CWL_BASE(3'h5)) dut_u (.clk, .reset, .avs_read,
      .avs_write, .avs_address, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .ck_pin, .cs_n_pin, .ras_n_pin,
      .cas_n_pin, .we_n_pin, .ba_pin, .addr_pin, .temp_hot_pin, .dq_o,
      .dq_oe_n, .term_wr_q, .term_wr_code, .sr_rate_2x_q, .array_rd_q,
      .array_wr_q, .total_write_delay);
   dmr_ctl_model ctl (.ck_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin,
      .we_n_pin, .ba_pin, .addr_pin);
   always #20 clk = ~clk;
   task results;
      if (error_cnt == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task av(input w, input [3:0] ad, input [31:0] d);
      int n;
      @(posedge clk);
      {avs_read, avs_write} <= {!w, w};
      avs_address <= ad;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      {avs_read, avs_write} <= 2'h0;
      if (n >= 50) begin
         error_cnt++;
         results;
      end
   endtask
   // one link command while beats, term cycles and pulses are counted
   task go(input wr, input bc, input hi);
      int k;
      bq.delete();
      tc = 0;
      ap = 0;
      k = 0;
      fork
         if (wr) ctl.wr(bc); else ctl.rd(bc, hi);
         repeat (300) begin
            @(negedge clk);
            tc += term_wr_q;
            ap += array_rd_q + array_wr_q;
            k = dq_oe_n ? 0 : k + 1;
            if (k % 4 == 3) bq.push_back(dq_o);
         end
      join
   endtask
   initial begin
      void'($urandom(32'h1d9d));
      {clk, avs_read, avs_write, temp_hot_pin} = 4'h0;
      reset = 1'b1;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // reset values and an unmapped hole
      av(0, 4'h8, 0);
      chk(q, 32'h4);
      av(0, 4'hC, 0);
      chk(q, 32'h0B00);
      av(0, 4'h1, 0);
      chk(q, 32'h0);
      // random second mode register, additive delay and temperature
      for (i = 0; i < 6; i++) begin
         m2 = 14'($urandom) & 14'h06F8;
         al = 5'($urandom);
         hot = 1'($urandom);
         temp_hot_pin <= hot;
         // extended range: a hot part gets a rate mode enabled
         if (hot && !m2[7]) m2[6] = 1'b1;
         av(1, 4'hC, {19'h58, al});
         ctl.mode_load_cmd(3'h2, m2);
         if (m2[7]) m2[6] = 1'b0;
         av(0, 4'h0, 0);
         chk(q, m2);
         av(0, 4'h4, 0);
         chk(q, m2[5:3] + 5 + al);
         chk(total_write_delay, m2[5:3] + 5 + al);
         chk(sr_rate_2x_q, m2[7] | m2[6] & temp_hot_pin);
         chk(term_wr_code, m2[10:9]);
      end
      // calibration reads: eight, chop low, chop high, all lanes
      av(1, 4'hC, 32'h0B00);
      ctl.mode_load_cmd(3'h3, 14'h0004);
      for (i = 0; i < 4; i++) begin
         if (i == 3) av(1, 4'h8, 32'h6);
         go(0, i == 1 || i == 2, i == 2);
         chk(bq.size(), (i == 1 || i == 2) ? 4 : 8);
         chk(ap, 0);
         foreach (bq[j]) chk(bq[j], (i == 3) ? {8{j[0]}} : j[0]);
      end
      // reserved pattern select gives nothing, then normal access
      ctl.mode_load_cmd(3'h3, 14'h0005);
      go(0, 0, 0);
      chk(bq.size() + ap, 0);
      ctl.mode_load_cmd(3'h3, 14'h0000);
      go(0, 0, 0);
      chk(ap, 1);
      // write termination: eight, chop, then write leveling
      ctl.mode_load_cmd(3'h2, 14'h0200);
      for (i = 0; i < 3; i++) begin
         av(1, 4'h8, (i == 2) ? 32'h5 : 32'h4);
         go(1, i == 1, 0);
         chk(ap, 1);
         chk(tc, (i == 0) ? 32 : (i == 1) ? 16 : 0);
      end
      results;
   end
endmodule
`default_nettype wire
